//--- rtl/dpct_timer.sv
// Dual PWM and capture timer with APB register access
//
// Implementation choices: the APB interface to the registers and the register offsets.
module dpct_timer #(
	parameter int unsigned CNT_W = dpct_pkg::CNT_W,
	parameter int unsigned DB_W = dpct_pkg::DB_W,
	parameter int unsigned PRE_W = dpct_pkg::PRE_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire dpct_pkg::dpct_apb_req_s apb_req,
	output dpct_pkg::dpct_apb_rsp_s apb_rsp,
	// Timer pins
	input wire logic timer_in_pin,
	output logic pwm_out,
	output logic pwm_n_out,
	output logic pwm_n_oe_n,
	// Timer interrupt pulse
	output logic timer_irq
);
	// Control state
	logic en_ff;
	logic [2:0] mode_ff;
	logic pol_ff;
	logic [2:0] pre_sel_ff;
	logic modehi_ff;
	logic [1:0] src_ff;
	logic cause_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] reload_ff;
	logic [CNT_W-1:0] match_ff;
	logic [DB_W-1:0] dead_ff;
	logic [PRE_W-1:0] pre_ff;
	logic pwm_raw_ff;
	logic irq_ff;
	logic oe_n_ff;
	dpct_pkg::dpct_apb_rsp_s rsp_ff;

	// Next values
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] nxt_match;
	logic [PRE_W-1:0] nxt_pre;
	logic nxt_pwm_raw;
	logic nxt_cause;
	logic nxt_irq;

	// Prescale factor 2^sel, the counter sees one tick per factor clocks
	function automatic logic [PRE_W-1:0] presc_last(input logic [2:0] sel);
		logic [PRE_W:0] factor;
		factor = (PRE_W+1)'(1) << sel;
		return PRE_W'(factor - 1'b1);
	endfunction : presc_last

	// Dead band above the maximum is held at the maximum
	function automatic logic [DB_W-1:0] dead_clamp(input logic [DB_W-1:0] v);
		return (v > DB_W'(dpct_pkg::DEAD_MAX)) ? DB_W'(dpct_pkg::DEAD_MAX) : v;
	endfunction : dead_clamp

	// Bus decode; a transfer completes on the edge where pready is high
	logic acc_done;
	logic wr_done;
	logic acc_first;
	logic hit_ctrl;
	logic hit_ctrl1;
	logic hit_count;
	logic hit_reload;
	logic hit_match;
	logic hit_dead;
	logic hit_any;
	assign acc_done = apb_req.psel & apb_req.penable & rsp_ff.pready;
	assign wr_done = acc_done & apb_req.pwrite;
	assign acc_first = apb_req.psel & apb_req.penable & ~rsp_ff.pready;
	assign hit_ctrl = (apb_req.paddr == dpct_pkg::OFS_CTRL);
	assign hit_ctrl1 = (apb_req.paddr == dpct_pkg::OFS_CTRL1);
	assign hit_count = (apb_req.paddr == dpct_pkg::OFS_COUNT);
	assign hit_reload = (apb_req.paddr == dpct_pkg::OFS_RELOAD);
	assign hit_match = (apb_req.paddr == dpct_pkg::OFS_MATCH);
	assign hit_dead = (apb_req.paddr == dpct_pkg::OFS_DEAD);
	assign hit_any = hit_ctrl | hit_ctrl1 | hit_count | hit_reload | hit_match | hit_dead;

	// Register write strobes
	logic ctrl_wr;
	logic ctrl1_wr;
	logic cnt_wr;
	logic reload_wr;
	logic match_wr;
	logic dead_wr;
	logic en_start;
	logic [31:0] wdata;
	assign wdata = apb_req.pwdata;
	assign ctrl_wr = wr_done & hit_ctrl;
	assign ctrl1_wr = wr_done & hit_ctrl1;
	assign cnt_wr = wr_done & hit_count;
	assign reload_wr = wr_done & hit_reload;
	assign match_wr = wr_done & hit_match;
	assign dead_wr = wr_done & hit_dead;
	assign en_start = ctrl_wr & wdata[dpct_pkg::CTRL_EN_BIT] & ~en_ff;

	// Mode decode from both control registers
	dpct_pkg::dpct_mode_t mode_code;
	logic dual;
	logic capm;
	logic rstm;
	logic active;
	assign mode_code = {modehi_ff, mode_ff};
	assign dual = (mode_code == dpct_pkg::MODE_DUAL_PWM);
	assign capm = (mode_code == dpct_pkg::MODE_CAPTURE);
	assign rstm = (mode_code == dpct_pkg::MODE_CAP_RESTART);
	assign active = en_ff & (dual | capm | rstm);

	// Timer input edges, unused while the pin drives the complement
	logic in_rise;
	logic in_fall;
	dpct_edge_sync u_edge (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(timer_in_pin),
		.rise(in_rise),
		.fall(in_fall)
	);

	// Tick, reload and capture events
	logic tick;
	logic at_reload;
	logic cap_ev;
	logic rel_ev;
	logic [CNT_W-1:0] cnt_inc;
	assign tick = active & (pre_ff == presc_last(pre_sel_ff));
	assign at_reload = tick & (cnt_ff == reload_ff);
	assign cap_ev = en_ff & (capm | rstm) & (pol_ff ? in_rise : in_fall);
	// A restart capture preempts a reload in the same cycle
	assign rel_ev = at_reload & ~(cap_ev & rstm);
	assign cnt_inc = cnt_ff + 1'b1;

	// Prescaler restarts with the period so each pass is exact
	assign nxt_pre = (!active || tick || (cap_ev && rstm)) ? '0 : pre_ff + 1'b1;

	// Counter: bus write, restart, reload, then plain count
	always_comb begin
		if (cnt_wr) begin
			nxt_cnt = wdata[CNT_W-1:0];
		end else if (cap_ev && rstm) begin
			nxt_cnt = CNT_W'(dpct_pkg::CNT_RESTART);
		end else if (rel_ev && (dual || rstm)) begin
			nxt_cnt = CNT_W'(dpct_pkg::CNT_RESTART);
		end else if (tick) begin
			nxt_cnt = cnt_inc;
		end else begin
			nxt_cnt = cnt_ff;
		end
	end

	// Capture beats a software write to the match register
	assign nxt_match = cap_ev ? cnt_ff : (match_wr ? wdata[CNT_W-1:0] : match_ff);

	// PWM level: start level on enable and reload, inverted at match
	always_comb begin
		if (en_start) begin
			nxt_pwm_raw = wdata[dpct_pkg::CTRL_POL_BIT];
		end else if (dual && rel_ev) begin
			nxt_pwm_raw = pol_ff;
		end else if (dual && tick && cnt_inc == match_ff) begin
			nxt_pwm_raw = ~pol_ff;
		end else begin
			nxt_pwm_raw = pwm_raw_ff;
		end
	end

	// Cause flag: capture sets, reload clears, set wins
	assign nxt_cause = cap_ev | (cause_ff & ~rel_ev);

	// Interrupt pulse filtered by the source select
	logic src_cap_ok;
	logic src_rel_ok;
	assign src_cap_ok = (src_ff != dpct_pkg::SRC_RELOAD);
	assign src_rel_ok = (src_ff != dpct_pkg::SRC_CAPTURE);
	assign nxt_irq = (cap_ev & src_cap_ok) | (rel_ev & src_rel_ok);

	// Read data mux, unused bits read zero
	logic [31:0] rd_data;
	assign rd_data =
		hit_ctrl ? 32'({pre_sel_ff, pol_ff, mode_ff, en_ff}) :
		hit_ctrl1 ? 32'({cause_ff, src_ff, modehi_ff}) :
		hit_count ? 32'(cnt_ff) :
		hit_reload ? 32'(reload_ff) :
		hit_match ? 32'(match_ff) :
		hit_dead ? 32'(dead_ff) : 32'h0000_0000;

	// APB answer one wait state after the access phase begins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.pready <= acc_first;
			rsp_ff.pslverr <= acc_first & ~hit_any;
			rsp_ff.prdata <= acc_first ? rd_data : 32'h0000_0000;
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			en_ff <= 1'b0;
			mode_ff <= 3'h0;
			pol_ff <= 1'b0;
			pre_sel_ff <= 3'h0;
			modehi_ff <= 1'b0;
			src_ff <= dpct_pkg::SRC_BOTH;
		end else begin
			if (ctrl_wr) begin
				en_ff <= wdata[dpct_pkg::CTRL_EN_BIT];
				mode_ff <= wdata[dpct_pkg::CTRL_MODE_LSB +: 3];
				pol_ff <= wdata[dpct_pkg::CTRL_POL_BIT];
				pre_sel_ff <= wdata[dpct_pkg::CTRL_PRE_LSB +: 3];
			end
			if (ctrl1_wr) begin
				modehi_ff <= wdata[dpct_pkg::CTRL1_MODEHI_BIT];
				src_ff <= wdata[dpct_pkg::CTRL1_SRC_LSB +: 2];
			end
		end
	end

	// Period and dead band registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reload_ff <= CNT_W'(dpct_pkg::RELOAD_RST);
			dead_ff <= '0;
		end else begin
			if (reload_wr) begin
				reload_ff <= wdata[CNT_W-1:0];
			end
			if (dead_wr) begin
				dead_ff <= dead_clamp(wdata[DB_W-1:0]);
			end
		end
	end

	// Counting state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_ff <= CNT_W'(dpct_pkg::CNT_RESTART);
			match_ff <= CNT_W'(dpct_pkg::MATCH_RST);
			pre_ff <= '0;
			pwm_raw_ff <= 1'b0;
			cause_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			match_ff <= nxt_match;
			pre_ff <= nxt_pre;
			pwm_raw_ff <= nxt_pwm_raw;
			cause_ff <= nxt_cause;
			irq_ff <= nxt_irq;
		end
	end

	// Shared pin turns to an output in dual PWM
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			oe_n_ff <= 1'b1;
		end else begin
			oe_n_ff <= ~dual;
		end
	end

	// Both outputs idle low outside dual PWM; each rise waits the dead band
	logic prim_level;
	logic comp_level;
	assign prim_level = dual & pwm_raw_ff;
	assign comp_level = dual & ~pwm_raw_ff;

	dpct_deadband #(.DB_W(DB_W)) u_db_prim (
		.sys_clk(sys_clk),
		.reset(reset),
		.level_in(prim_level),
		.dead_cycles(dead_ff),
		.level_out(pwm_out)
	);

	dpct_deadband #(.DB_W(DB_W)) u_db_comp (
		.sys_clk(sys_clk),
		.reset(reset),
		.level_in(comp_level),
		.dead_cycles(dead_ff),
		.level_out(pwm_n_out)
	);

	// Output hookup
	assign apb_rsp = rsp_ff;
	assign timer_irq = irq_ff;
	assign pwm_n_oe_n = oe_n_ff;

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	sequence s_reload_hit;
		rel_ev && !cnt_wr && (dual || rstm);
	endsequence

	sequence s_restart_cap;
		cap_ev && rstm && !cnt_wr;
	endsequence

	a_reload_restart: assert property (s_reload_hit |=> cnt_ff == CNT_W'(dpct_pkg::CNT_RESTART))
		else $error("count not restarted at reload");
	a_capture_stores: assert property (cap_ev |=> match_ff == $past(cnt_ff))
		else $error("capture value not stored");
	// Set wins over a same-cycle reload, so every capture leaves the flag up
	a_cap_flag_set: assert property (cap_ev |=> cause_ff)
		else $error("cause flag not set by capture");
	a_cap_flag_clr: assert property (rel_ev && !cap_ev |=> !cause_ff)
		else $error("cause flag not cleared by reload");
	a_restart_cap: assert property (s_restart_cap |=>
		cnt_ff == CNT_W'(dpct_pkg::CNT_RESTART) && irq_ff == $past(src_cap_ok))
		else $error("restart capture wrong");
	// The enabling write itself loads the start level, so it is left out
	a_hold_disabled: assert property (!en_ff && !cnt_wr && !en_start
		|=> $stable(cnt_ff) && $stable(pwm_raw_ff))
		else $error("disabled timer moved");
	a_dead_gap: assert property (!(pwm_out && pwm_n_out))
		else $error("both PWM outputs high");
	a_src_filter: assert property (rel_ev && !cap_ev && src_ff == dpct_pkg::SRC_CAPTURE |=> !timer_irq)
		else $error("reload interrupt not filtered");
	a_match_level: assert property (dual && tick && !rel_ev && !en_start && cnt_inc == match_ff
		|=> pwm_raw_ff == !$past(pol_ff))
		else $error("PWM level wrong after match");
	a_pin_switch: assert property (dual |=> !pwm_n_oe_n ##0 !cap_ev)
		else $error("shared pin not driving in dual PWM");
endmodule : dpct_timer

//--- rtl/dpct_pkg.sv
// Constants, mode codes and bus carriers for the dual PWM capture timer
package dpct_pkg;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DB_W = 8;
	localparam int unsigned PRE_W = 7;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_RELOAD = 8'h0c;
	localparam logic [7:0] OFS_MATCH = 8'h10;
	localparam logic [7:0] OFS_DEAD = 8'h14;

	// Main control register fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_POL_BIT = 4;
	localparam int unsigned CTRL_PRE_LSB = 5;

	// Second control register fields
	localparam int unsigned CTRL1_MODEHI_BIT = 0;
	localparam int unsigned CTRL1_SRC_LSB = 1;
	localparam int unsigned CTRL1_CAUSE_BIT = 3;

	// Mode codes: mode high bit above the three-bit main field
	typedef logic [3:0] dpct_mode_t;
	localparam dpct_mode_t MODE_DUAL_PWM = 4'h8;
	localparam dpct_mode_t MODE_CAPTURE = 4'h4;
	localparam dpct_mode_t MODE_CAP_RESTART = 4'h9;

	// Interrupt source select
	typedef enum logic [1:0] {
		SRC_BOTH = 2'h0,
		SRC_CAPTURE = 2'h1,
		SRC_RELOAD = 2'h2,
		SRC_BOTH_ALT = 2'h3
	} dpct_src_e;

	// Reset and restart values, and the dead band clamp limit
	localparam logic [15:0] CNT_RESTART = 16'h0001;
	localparam logic [15:0] RELOAD_RST = 16'hffff;
	localparam logic [15:0] MATCH_RST = 16'h0000;
	localparam logic [7:0] DEAD_MAX = 8'h80;

	// APB request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dpct_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dpct_apb_rsp_s;
endpackage : dpct_pkg

//--- rtl/dpct_edge_sync.sv
// Two-flop input synchroniser with rise and fall detection
module dpct_edge_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Asynchronous pin level
	input wire logic pin_in,
	// One-cycle edge pulses
	output logic rise,
	output logic fall
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// Only sync_ff and prev_ff feed the edge logic
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Edge pulses
	assign rise = sync_ff & ~prev_ff;
	assign fall = ~sync_ff & prev_ff;
endmodule : dpct_edge_sync

//--- rtl/dpct_deadband.sv
// Delays the rising edge of one PWM level by a dead time
module dpct_deadband #(
	parameter int unsigned DB_W = dpct_pkg::DB_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Level and dead time in cycles
	input wire logic level_in,
	input wire logic [DB_W-1:0] dead_cycles,
	// Delayed level
	output logic level_out
);
	logic [DB_W-1:0] wait_ff;
	logic out_ff;
	logic done;
	logic nxt_out;
	logic [DB_W-1:0] nxt_wait;

	// Falls pass at once, rises wait out the dead time
	assign done = (wait_ff >= dead_cycles);
	assign nxt_out = level_in & (out_ff | done);
	assign nxt_wait = (!level_in || out_ff || done) ? '0 : wait_ff + 1'b1;
	assign level_out = out_ff;

	// Dead-time state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wait_ff <= '0;
			out_ff <= 1'b0;
		end else begin
			wait_ff <= nxt_wait;
			out_ff <= nxt_out;
		end
	end

	// Deassertion is never delayed
	a_fall_fast: assert property (@(posedge sys_clk) disable iff (reset)
		!level_in |=> !out_ff) else $error("deadband output late to fall");
endmodule : dpct_deadband

//--- verification/dpct_gpio_model.sv
// Pin model for the shared timer input and complement output
module dpct_gpio_model (
	// Timer side of the shared pin
	input wire logic pwm_n_out,
	input wire logic pwm_n_oe_n,
	// Level from the outside circuit while the pin is an input
	input wire logic drive_level,
	// Resolved pin level
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// Timer owns the pin while its enable is low; outside driver is cut off then
	assign pin_level = pwm_n_oe_n ? drive_level : pwm_n_out;
endmodule : dpct_gpio_model

//--- verification/test_dual_pwm_capture_timer.sv
// Self-checking bench for the dual PWM capture timer
module test_dual_pwm_capture_timer;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	dpct_pkg::dpct_apb_req_s req = '0;
	dpct_pkg::dpct_apb_rsp_s rsp;
	logic drv_lvl = 1'b0;
	logic pin;
	logic pwm_out;
	logic pwm_n_out;
	logic pwm_n_oe_n;
	logic timer_irq;
	logic [31:0] rdat;
	logic rerr;
	int n_fail = 0;
	int num_checks = 0;
	int t;
	int hp;
	int hn;
	int ov;
	int bad;
	logic [31:0] m;
	localparam logic [7:0] OFS [6] = '{dpct_pkg::OFS_CTRL, dpct_pkg::OFS_CTRL1,
		dpct_pkg::OFS_COUNT, dpct_pkg::OFS_RELOAD, dpct_pkg::OFS_MATCH, dpct_pkg::OFS_DEAD};
	localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'h1, 32'hffff, 32'h0, 32'h0};

	// 25 MHz clock
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	dpct_timer i_dut (.sys_clk(sys_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
		.timer_in_pin(pin), .pwm_out(pwm_out), .pwm_n_out(pwm_n_out),
		.pwm_n_oe_n(pwm_n_oe_n), .timer_irq(timer_irq));
	dpct_gpio_model i_gpio (.pwm_n_out(pwm_n_out), .pwm_n_oe_n(pwm_n_oe_n),
		.drive_level(drv_lvl), .pin_level(pin));

	// Verdict and end of run
	task report_and_stop;
		if (n_fail == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			if (rsp.pready === 1'b1) break;
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (i == 16) begin
			n_fail++;
			report_and_stop();
		end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rdat);
	endtask : rdc

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// Cycles until the next interrupt pulse, -1 if none within the limit
	task wirq(input int lim);
		int k;
		t = -1;
		for (k = 1; k <= lim; k++) begin
			@(posedge sys_clk);
			if (timer_irq === 1'b1) begin
				t = k;
				break;
			end
		end
	endtask : wirq

	// High time of both outputs over a window, plus overlap and pin faults
	task meas(input int n);
		hp = 0;
		hn = 0;
		ov = 0;
		bad = 0;
		repeat (n) begin
			@(posedge sys_clk);
			hp += int'(pwm_out === 1'b1);
			hn += int'(pwm_n_out === 1'b1);
			ov += int'(pwm_out === 1'b1 && pwm_n_out === 1'b1);
			bad += int'(pwm_n_oe_n !== 1'b0 || pin !== pwm_n_out);
		end
	endtask : meas

	initial begin
		cyc(6);
		reset <= 1'b0;
		for (int p = 0; p < 6; p++) begin
			rdc("reset value", OFS[p], RV[p]);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, 32'(rerr));
		chk("unmapped data", 32'h0, rdat);
		wr(dpct_pkg::OFS_DEAD, 32'hff);
		rdc("dead clamp", dpct_pkg::OFS_DEAD, 32'h80);
		wr(dpct_pkg::OFS_COUNT, 32'h5);
		cyc(10);
		rdc("disabled hold", dpct_pkg::OFS_COUNT, 32'h5);
		// Dual PWM over both polarities and two prescale factors
		for (int p = 0; p < 2; p++) begin
			for (int n = 0; n < 2; n++) begin
				wr(dpct_pkg::OFS_CTRL, 32'h0);
				wr(dpct_pkg::OFS_CTRL1, 32'h1);
				wr(dpct_pkg::OFS_COUNT, 32'd10);
				wr(dpct_pkg::OFS_MATCH, 32'd5);
				wr(dpct_pkg::OFS_DEAD, 32'd2);
				wr(dpct_pkg::OFS_RELOAD, 32'd12);
				wr(dpct_pkg::OFS_CTRL, 32'(1 | (p << 4) | (n << 5)));
				wirq(8 << n);
				chk("first pass", 32'h1, 32'(t > 0));
				wirq(40 << n);
				chk("period", 32'(12 << n), 32'(t));
				meas(12 << n);
				chk("pwm high", 32'(p ? (4 << n) - 2 : (8 << n) - 2), 32'(hp));
				chk("cpl high", 32'(p ? (8 << n) - 2 : (4 << n) - 2), 32'(hn));
				chk("overlap", 32'h0, 32'(ov));
				chk("shared pin", 32'h0, 32'(bad));
			end
		end
		// Capture mode, rising edge
		wr(dpct_pkg::OFS_CTRL, 32'h0);
		wr(dpct_pkg::OFS_CTRL1, 32'h0);
		wr(dpct_pkg::OFS_COUNT, 32'h1);
		wr(dpct_pkg::OFS_RELOAD, 32'hffff);
		wr(dpct_pkg::OFS_MATCH, 32'h0);
		wr(dpct_pkg::OFS_CTRL, 32'h19);
		cyc(20);
		apb(1'b0, dpct_pkg::OFS_COUNT, 32'h0);
		m = rdat;
		drv_lvl <= 1'b1;
		wirq(10);
		chk("capture irq", 32'h1, 32'(t > 0));
		apb(1'b0, dpct_pkg::OFS_MATCH, 32'h0);
		chk("capture count", 32'h1, 32'(rdat - m >= 1 && rdat - m <= 8));
		m = rdat;
		rdc("cause set", dpct_pkg::OFS_CTRL1, 32'h8);
		apb(1'b0, dpct_pkg::OFS_COUNT, 32'h0);
		chk("count runs on", 32'h1, 32'(rdat > m + 4));
		drv_lvl <= 1'b0;
		wirq(10);
		chk("falling ignored", 32'h1, 32'(t < 0));
		wr(dpct_pkg::OFS_COUNT, 32'hfff0);
		wirq(40);
		chk("reload irq", 32'h1, 32'(t > 0));
		rdc("cause clear", dpct_pkg::OFS_CTRL1, 32'h0);
		// Capture-restart mode, falling edge
		wr(dpct_pkg::OFS_CTRL, 32'h2);
		drv_lvl <= 1'b1;
		wr(dpct_pkg::OFS_CTRL1, 32'h1);
		wr(dpct_pkg::OFS_COUNT, 32'h1);
		wr(dpct_pkg::OFS_RELOAD, 32'h100);
		wr(dpct_pkg::OFS_MATCH, 32'h0);
		wr(dpct_pkg::OFS_CTRL, 32'h3);
		cyc(30);
		drv_lvl <= 1'b0;
		wirq(10);
		chk("restart irq", 32'h1, 32'(t > 0));
		apb(1'b0, dpct_pkg::OFS_COUNT, 32'h0);
		chk("restarted", 32'h1, 32'(rdat < 32'h10));
		apb(1'b0, dpct_pkg::OFS_MATCH, 32'h0);
		chk("stored count", 32'h1, 32'(rdat >= 32'd30 && rdat <= 32'd45));
		rdc("restart cause", dpct_pkg::OFS_CTRL1, 32'h9);
		chk("pin is input", 32'h1, 32'(pwm_n_oe_n));
		wirq(300);
		wirq(300);
		chk("restart period", 32'h100, 32'(t));
		rdc("reload cause", dpct_pkg::OFS_CTRL1, 32'h1);
		// Interrupt source select, codes SRC_CAPTURE, SRC_RELOAD and SRC_BOTH_ALT
		wr(dpct_pkg::OFS_CTRL1, 32'h3);
		wirq(300);
		chk("reload masked", 32'h1, 32'(t < 0));
		drv_lvl <= 1'b1;
		cyc(4);
		drv_lvl <= 1'b0;
		wirq(10);
		chk("capture kept", 32'h1, 32'(t > 0));
		wr(dpct_pkg::OFS_CTRL1, 32'h5);
		drv_lvl <= 1'b1;
		cyc(4);
		drv_lvl <= 1'b0;
		wirq(10);
		chk("capture masked", 32'h1, 32'(t < 0));
		wirq(300);
		chk("reload kept", 32'h1, 32'(t > 0));
		wr(dpct_pkg::OFS_CTRL1, 32'h7);
		wirq(300);
		chk("both again", 32'h1, 32'(t > 0));
		report_and_stop();
	end
endmodule : test_dual_pwm_capture_timer
